// >>> src/cmt_scrub_pkg.sv
// package: register map, field layout, timing and types of the cmt scrub/trigger block
package cmt_scrub_pkg;

  // control bus register offsets
  localparam logic [5:0] ADDR_MASK   = 6'h21;
  localparam logic [5:0] ADDR_RSV_A  = 6'h22;
  localparam logic [5:0] ADDR_RSV_B  = 6'h23;
  localparam logic [5:0] ADDR_THRESH = 6'h24;
  localparam logic [5:0] ADDR_SNAP   = 6'h25;
  localparam logic [5:0] ADDR_TRIG   = 6'h26;

  // field positions
  localparam int MASK_STE_BIT  = 6;
  localparam int MASK_TCO_BIT  = 7;
  localparam int TRIG_MODE_LSB = 0;
  localparam int TRIG_MODE_MSB = 2;
  localparam int TRIG_EN_LSB   = 3;
  localparam int TRIG_EN_MSB   = 7;

  // reset values and stored mask bits
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [7:0] TRIG_RST   = 8'h00;
  localparam logic [7:0] MASK_USED  = 8'hC0;

  // timing: one scrub timer step is 40.96 us
  localparam int CLK_PERIOD_PS = 50000;
  localparam int TICK_PS       = 40960000;
  localparam int TICK_CYC      = TICK_PS / CLK_PERIOD_PS;
  localparam int INVALID_SYMS  = 2;

  // line symbols
  localparam logic [4:0] SYM_IDLE  = 5'h1F;
  localparam logic [4:0] SYM_HALT  = 5'h04;
  localparam logic [4:0] SYM_QUIET = 5'h00;

  // transmit modes
  typedef enum logic [2:0] {
    TX_ACTIVE = 3'b000,
    TX_IDLE   = 3'b001,
    TX_OFF    = 3'b010,
    TX_RSV3   = 3'b011,
    TX_MASTER = 3'b100,
    TX_HALT   = 3'b101,
    TX_QUIET  = 3'b110,
    TX_RSV7   = 3'b111
  } tx_mode_t;

  // scrub symbol phase
  typedef enum logic [1:0] {
    SCRUB_OFF     = 2'b00,
    SCRUB_INVALID = 2'b01,
    SCRUB_PAIRS   = 2'b10
  } scrub_phase_t;

  // trigger sources, same order as trigger_definition bits 7..3
  typedef struct packed {
    logic noise;
    logic quiet;
    logic halt;
    logic master;
    logic super_idle;
  } line_cond_t;

  // one control bus request
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cbus_req_t;

endpackage

// >>> src/scrub_timer.sv
// scrub timer: 40.96 us prescaler and 8-bit down counter
`timescale 1ns/10ps
module scrub_timer import cmt_scrub_pkg::*; #(
  parameter int TICK = TICK_CYC,
  parameter int CW   = 8
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          start,
  input  wire logic [CW-1:0] load_val,
  output logic      [CW-1:0] count_q,
  output logic               busy_q,
  output logic               expire_q
);

  // elaboration check: the prescaler is only 16 bits wide
  if (TICK < 1 || TICK > 65535 || CW < 1) begin
    $error("scrub_timer: bad parameters");
  end

  logic [15:0] pre_q;
  logic        tick;

  assign tick = (pre_q == 16'(TICK - 1));

  ////////////////////////////////////////////////////////////////
  // prescaler restarts with each scrub so the first step is whole
  always_ff @(posedge clk) begin
    if (!rstn || !busy_q || tick) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  // down counter; start is ignored while busy so the run keeps its length
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q  <= '0;
      busy_q   <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (start && !busy_q) begin
        count_q <= load_val;
        busy_q  <= 1'b1;
      end else if (busy_q && tick) begin
        if (count_q <= CW'(1)) begin
          count_q  <= '0;
          busy_q   <= 1'b0;
          expire_q <= 1'b1;
        end else begin
          count_q <= count_q - CW'(1);
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // between steps the count holds; an early step would shorten the scrub
  chk_tick_spacing: assert property (
    busy_q && !tick |=> busy_q && count_q == $past(count_q))
    else $error("scrub step shorter than expected");

endmodule

// >>> src/cmt_scrub_trigger.sv
// cmt condition mask, scrub timer registers and trigger definition logic
`timescale 1ns/10ps
module cmt_scrub_trigger import cmt_scrub_pkg::*; #(
  parameter int TICK = TICK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  cbus_req_t       cb_req,
  output logic [7:0]      cb_rdata_q,
  output logic            cb_ack_q,
  output logic            write_reject_q,
  input  line_cond_t      line_cond,
  input  wire logic       enable_scrub_on_trigger,
  input  wire logic [1:0] flag_clear,
  input  wire logic       tx_mode_wr,
  input  tx_mode_t        tx_mode_wdata,
  input  wire logic [9:0] mac_pair,
  output logic            trigger_occurred_flag_q,
  output logic            scrub_expired_flag_q,
  output logic            connection_service_event_q,
  output logic            config_wp_q,
  output tx_mode_t        cur_tx_mode_q,
  output logic [9:0]      tx_pair_q,
  output logic            txe_q,
  output scrub_phase_t    scrub_phase_q
);

  // elaboration check: the timer prescaler is 16 bits wide
  if (TICK < 1 || TICK > 65535) begin
    $error("cmt_scrub_trigger: TICK out of range");
  end

  ////////////////////////////////////////////////////////////////
  // registers and internal signals
  logic [7:0]  cmt_condition_mask_q;
  logic [7:0]  scrub_threshold_q;
  logic [7:0]  trigger_definition_q;
  line_cond_t  cond_prev_q;
  logic [4:0]  cond_rise;
  logic        trigger;
  logic        scrub_start;
  logic        wr_en;
  logic        tco_d;
  logic        ste_d;
  logic [7:0]  timer_count;
  logic        timer_busy;
  logic        timer_expire;
  logic [1:0]  inv_cnt_q;
  tx_mode_t    trig_mode;

  assign wr_en = cb_req.sel && cb_req.wr;
  assign trig_mode = tx_mode_t'(trigger_definition_q[TRIG_MODE_MSB:TRIG_MODE_LSB]);

  ////////////////////////////////////////////////////////////////
  // trigger detection: a source fires on entry into its condition,
  // so a line state that persists does not retrigger every cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cond_prev_q <= '0;
    end else begin
      cond_prev_q <= line_cond;
    end
  end

  assign cond_rise = line_cond & ~cond_prev_q;
  assign trigger = |(cond_rise & trigger_definition_q[TRIG_EN_MSB:TRIG_EN_LSB]);
  assign scrub_start = trigger && enable_scrub_on_trigger;

  ////////////////////////////////////////////////////////////////
  // host writable registers; reserved mask bits are not stored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmt_condition_mask_q <= MASK_RST;
    end else if (wr_en && cb_req.addr == ADDR_MASK) begin
      cmt_condition_mask_q <= cb_req.wdata & MASK_USED;
    end
  end

  // the timer copies the threshold only at scrub start, so a late
  // write changes the next scrub, never the current one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scrub_threshold_q <= THRESH_RST;
    end else if (wr_en && cb_req.addr == ADDR_THRESH) begin
      scrub_threshold_q <= cb_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      trigger_definition_q <= TRIG_RST;
    end else if (wr_en && cb_req.addr == ADDR_TRIG) begin
      trigger_definition_q <= cb_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus answer: one cycle after the request; reserved and foreign
  // addresses read zero and swallow writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cb_rdata_q <= 8'h00;
      cb_ack_q   <= 1'b0;
    end else begin
      cb_ack_q <= cb_req.sel;
      if (cb_req.sel && !cb_req.wr) begin
        case (cb_req.addr)
          ADDR_MASK:   cb_rdata_q <= cmt_condition_mask_q;
          ADDR_THRESH: cb_rdata_q <= scrub_threshold_q;
          ADDR_SNAP:   cb_rdata_q <= timer_count;
          ADDR_TRIG:   cb_rdata_q <= trigger_definition_q;
          ADDR_RSV_A:  cb_rdata_q <= 8'h00;
          ADDR_RSV_B:  cb_rdata_q <= 8'h00;
          default:     cb_rdata_q <= 8'h00;
        endcase
      end else begin
        cb_rdata_q <= 8'h00;
      end
    end
  end

  // write reject: one-cycle pulse that sets the reject bit elsewhere
  always_ff @(posedge clk) begin
    if (!rstn) begin
      write_reject_q <= 1'b0;
    end else begin
      write_reject_q <= wr_en && cb_req.addr == ADDR_SNAP;
    end
  end

  ////////////////////////////////////////////////////////////////
  // condition flags: a set in the clearing cycle wins over the clear
  always_comb begin
    tco_d = trigger_occurred_flag_q;
    ste_d = scrub_expired_flag_q;
    if (flag_clear[1]) tco_d = 1'b0;
    if (flag_clear[0]) ste_d = 1'b0;
    if (trigger) tco_d = 1'b1;
    if (timer_expire) ste_d = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      trigger_occurred_flag_q <= 1'b0;
      scrub_expired_flag_q    <= 1'b0;
      config_wp_q             <= 1'b0;
    end else begin
      trigger_occurred_flag_q <= tco_d;
      scrub_expired_flag_q    <= ste_d;
      config_wp_q             <= ste_d;
    end
  end

  // service event follows masked flags one cycle later
  always_ff @(posedge clk) begin
    if (!rstn) begin
      connection_service_event_q <= 1'b0;
    end else begin
      connection_service_event_q <=
        (trigger_occurred_flag_q && cmt_condition_mask_q[MASK_TCO_BIT]) ||
        (scrub_expired_flag_q && cmt_condition_mask_q[MASK_STE_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // current transmit mode: trigger load beats a host write; host
  // writes are dropped while the trigger flag protects the register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cur_tx_mode_q <= TX_ACTIVE;
    end else if (trigger) begin
      cur_tx_mode_q <= trig_mode;
    end else if (tx_mode_wr && !trigger_occurred_flag_q) begin
      cur_tx_mode_q <= tx_mode_wdata;
    end
  end

  // symbol pairs per mode; reserved codes fall back to quiet
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_pair_q <= {SYM_QUIET, SYM_QUIET};
      txe_q     <= 1'b0;
    end else begin
      txe_q <= (cur_tx_mode_q != TX_OFF);
      case (cur_tx_mode_q)
        TX_ACTIVE: tx_pair_q <= mac_pair;
        TX_IDLE:   tx_pair_q <= {SYM_IDLE, SYM_IDLE};
        TX_MASTER: tx_pair_q <= {SYM_HALT, SYM_QUIET};
        TX_HALT:   tx_pair_q <= {SYM_HALT, SYM_HALT};
        default:   tx_pair_q <= {SYM_QUIET, SYM_QUIET};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // scrub timer
  scrub_timer #(
    .TICK (TICK),
    .CW   (8)
  ) u_timer (
    .clk      (clk),
    .rstn     (rstn),
    .start    (scrub_start),
    .load_val (scrub_threshold_q),
    .count_q  (timer_count),
    .busy_q   (timer_busy),
    .expire_q (timer_expire)
  );

  // scrub phase: invalid symbols first, then scrub pairs to expiry
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scrub_phase_q <= SCRUB_OFF;
      inv_cnt_q     <= 2'h0;
    end else begin
      case (scrub_phase_q)
        SCRUB_OFF: begin
          if (scrub_start) begin
            scrub_phase_q <= SCRUB_INVALID;
            inv_cnt_q     <= 2'h0;
          end
        end
        SCRUB_INVALID: begin
          inv_cnt_q <= inv_cnt_q + 2'h1;
          if (inv_cnt_q == 2'(INVALID_SYMS - 1)) begin
            scrub_phase_q <= timer_expire ? SCRUB_OFF : SCRUB_PAIRS;
          end
        end
        SCRUB_PAIRS: begin
          if (timer_expire) begin
            scrub_phase_q <= SCRUB_OFF;
          end
        end
        default: scrub_phase_q <= SCRUB_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_cse_event: assert property (
    (trigger_occurred_flag_q && cmt_condition_mask_q[7]) ||
    (scrub_expired_flag_q && cmt_condition_mask_q[6]) |=> connection_service_event_q)
    else $error("service event missing");
  chk_mask_rsvd: assert property (cmt_condition_mask_q[5:0] == 6'h00)
    else $error("reserved mask bits stored");
  chk_expire_flag: assert property (timer_expire |=> scrub_expired_flag_q)
    else $error("expired flag not set");
  chk_scrub_start: assert property (
    scrub_start && scrub_phase_q == SCRUB_OFF |=> scrub_phase_q == SCRUB_INVALID && timer_busy)
    else $error("enabled trigger did not start scrub");
  chk_scrub_gate: assert property (
    scrub_phase_q == SCRUB_OFF && !(trigger && enable_scrub_on_trigger)
    |=> scrub_phase_q == SCRUB_OFF)
    else $error("scrub began without enabled trigger");
  chk_thresh_keep: assert property (
    timer_busy && timer_count > 8'h01 |=> timer_busy && timer_count <= $past(timer_count))
    else $error("scrub disturbed");
  chk_snap_read: assert property (
    cb_req.sel && !cb_req.wr && cb_req.addr == ADDR_SNAP |=> cb_rdata_q == $past(timer_count))
    else $error("snapshot wrong");
  chk_write_reject: assert property (
    wr_en && cb_req.addr == ADDR_SNAP |=> write_reject_q ##1 !write_reject_q || $past(wr_en))
    else $error("reject not flagged");
  chk_mode_copy: assert property (
    trigger |=> cur_tx_mode_q == $past(trig_mode) && trigger_occurred_flag_q)
    else $error("trigger mode not loaded");
  chk_active_pass: assert property (
    cur_tx_mode_q == TX_ACTIVE |=> tx_pair_q == $past(mac_pair) && txe_q)
    else $error("active mode broken");
  chk_off_pair: assert property (
    cur_tx_mode_q == TX_OFF |=> tx_pair_q == 10'h000 && !txe_q)
    else $error("off mode broken");
  chk_transmit_state_register_lock: assert property (
    trigger_occurred_flag_q && !trigger |=> $stable(cur_tx_mode_q))
    else $error("protected mode written");
  chk_invalid_two: assert property (
    $rose(scrub_phase_q == SCRUB_INVALID) |-> (scrub_phase_q == SCRUB_INVALID) [*2])
    else $error("invalid count wrong");

  cov_trigger: cover property (trigger);
  cov_scrub_run: cover property (scrub_phase_q == SCRUB_PAIRS ##[1:1000] timer_expire);
  cov_reject: cover property (write_reject_q);
  cov_cse: cover property ($rose(connection_service_event_q));

endmodule

// >>> sim/cbus_host.sv
// control bus host model: single-cycle requests, answer taken one edge later
`timescale 1ns/10ps
module cbus_host import cmt_scrub_pkg::*; (
  input  wire logic       clk,
  input  wire logic [7:0] cb_rdata_q,
  input  wire logic       cb_ack_q,
  output cbus_req_t       cb_req
);
  initial cb_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  // the block takes sel on one edge only, so sel is held for exactly one edge
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    // callers never aim at the reserved pair 22h/23h
    @(posedge clk);
    cb_req <= '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    @(posedge clk);
    cb_req <= '{sel: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};  // no stale value left
    #1;
    q = cb_rdata_q;
    ok = cb_ack_q;
  endtask
endmodule

// >>> sim/cmt_scrub_trigger_tb_top.sv
// self-checking bench for the cmt scrub and trigger block
`timescale 1ns/10ps
module cmt_scrub_trigger_tb_top import cmt_scrub_pkg::*;
;
  localparam int TK = 4;  // short tick keeps the test scrub to about a dozen cycles
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic         esot = 1'b0;
  logic         tx_mode_wr = 1'b0;
  logic [1:0]   flag_clear = '0;
  logic [9:0]   mac_pair = '0;
  line_cond_t   line_cond = '0;
  tx_mode_t     tx_mode_wdata = TX_ACTIVE;
  cbus_req_t    cb_req;
  logic [7:0]   cb_rdata_q, q;
  logic         cb_ack_q, write_reject_q, trig_q, exp_q, cse_q, wp_q, txe_q, ok;
  tx_mode_t     cur_tx_mode_q;
  logic [9:0]   tx_pair_q;
  scrub_phase_t scrub_phase_q;
  int           error_cnt = 0, samples_checked = 0;
  int           inv_cnt = 0, pair_cnt = 0, rej_cnt = 0, a, b;
  int           m_mask, m_thr, m_trig;  // register model

  initial forever #25 clk = ~clk;

  cmt_scrub_trigger #(.TICK(TK)) cmt_scrub_trigger_i (
    .clk(clk), .rstn(rstn), .cb_req(cb_req), .cb_rdata_q(cb_rdata_q),
    .cb_ack_q(cb_ack_q), .write_reject_q(write_reject_q), .line_cond(line_cond),
    .enable_scrub_on_trigger(esot), .flag_clear(flag_clear), .tx_mode_wr(tx_mode_wr),
    .tx_mode_wdata(tx_mode_wdata), .mac_pair(mac_pair), .trigger_occurred_flag_q(trig_q),
    .scrub_expired_flag_q(exp_q), .connection_service_event_q(cse_q),
    .config_wp_q(wp_q), .cur_tx_mode_q(cur_tx_mode_q), .tx_pair_q(tx_pair_q),
    .txe_q(txe_q), .scrub_phase_q(scrub_phase_q));

  cbus_host cbus_host_i (.clk(clk), .cb_rdata_q(cb_rdata_q), .cb_ack_q(cb_ack_q),
                         .cb_req(cb_req));

  ////////////////////////////////////////////////////////////////////////////
  // phase counters read as differences around a scenario, reject counter read as a total
  always @(posedge clk) begin
    inv_cnt <= inv_cnt + (scrub_phase_q == SCRUB_INVALID);
    pair_cnt <= pair_cnt + (scrub_phase_q == SCRUB_PAIRS);
    rej_cnt <= rej_cnt + write_reject_q;
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rd(input logic [5:0] ad, input logic [7:0] e);
    cbus_host_i.xfer(1'b0, ad, 8'h00, q, ok);
    chk({1'b0, ok, q}, {2'b01, e}, "read");
  endtask

  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    cbus_host_i.xfer(1'b1, ad, d, q, ok);
    chk({9'h000, ok}, 10'h001, "write ack");
  endtask

  task automatic clr();
    @(posedge clk);
    flag_clear <= 2'b11;
    @(posedge clk);
    flag_clear <= 2'b00;
    @(posedge clk);
  endtask

  // one-cycle entry into a line condition, bounded wait for the flag
  task automatic fire(input int i);
    int k;
    @(posedge clk);
    line_cond <= line_cond_t'(5'h01 << i);
    @(posedge clk);
    line_cond <= '0;
    for (k = 0; k < 3 && trig_q !== 1'b1; k++) begin
      @(posedge clk);
    end
    #1;
  endtask

  function automatic logic [9:0] pair_of(input int m, input logic [9:0] mac);
    case (m)
      0: return mac;
      1: return {SYM_IDLE, SYM_IDLE};
      4: return {SYM_HALT, SYM_QUIET};
      5: return {SYM_HALT, SYM_HALT};
      default: return {SYM_QUIET, SYM_QUIET};
    endcase
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #(3000 * 50);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    void'($urandom(27));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_MASK, MASK_RST);
    rd(ADDR_THRESH, THRESH_RST);
    rd(ADDR_TRIG, TRIG_RST);
    rd(6'h30, 8'h00);
    chk({6'h0, txe_q, cur_tx_mode_q}, {7'h01, TX_ACTIVE}, "reset tx");
    m_mask = $urandom;
    wr(ADDR_MASK, 8'(m_mask));
    rd(ADDR_MASK, 8'(m_mask) & MASK_USED);
    m_thr = $urandom;
    wr(ADDR_THRESH, 8'(m_thr));
    rd(ADDR_THRESH, 8'(m_thr));
    wr(ADDR_SNAP, 8'hA5);
    rd(ADDR_SNAP, 8'h00);
    chk(10'(rej_cnt), 10'd1, "write reject");
    $display("test registers done");
    // every mode code, sources taken in turn
    for (int m = 0; m < 8; m++) begin
      m_trig = (1 << (3 + m % 5)) | m;
      wr(ADDR_TRIG, 8'(m_trig));
      rd(ADDR_TRIG, 8'(m_trig));
      clr();
      mac_pair <= 10'($urandom);
      fire(m % 5);
      chk({9'h0, trig_q}, 10'h001, "trigger flag");
      chk(10'(cur_tx_mode_q), 10'(m), "mode load");
      repeat (2) @(posedge clk);
      #1;
      chk(tx_pair_q, pair_of(m, mac_pair), "pair");
      chk({txe_q, cse_q}, {m != 2, m_mask[7]}, "txe cse");
      chk(10'(scrub_phase_q), 10'(SCRUB_OFF), "no scrub");
    end
    clr();
    fire(4);
    chk({9'h0, trig_q}, 10'h000, "disabled source");
    fire(2);  // enabled source raises the flag that guards the mode register
    // host mode write refused while the flag stands, taken once cleared
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      tx_mode_wr <= 1'b1;
      tx_mode_wdata <= TX_HALT;
      @(posedge clk);
      tx_mode_wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(10'(cur_tx_mode_q), j ? 10'(TX_HALT) : 10'(TX_RSV7), "mode protect");
      clr();
    end
    $display("test triggers done");
    wr(ADDR_MASK, 8'h40);
    wr(ADDR_THRESH, 8'h03);
    @(posedge clk);
    esot <= 1'b1;
    a = inv_cnt;
    b = pair_cnt;
    fire(2);  // halt source is the one left enabled
    wr(ADDR_THRESH, 8'hFF);
    cbus_host_i.xfer(1'b0, ADDR_SNAP, 8'h00, q, ok);
    chk({9'h0, q inside {[1 : 3]}}, 10'h001, "snapshot");
    for (int k = 0; k < 40 && exp_q !== 1'b1; k++) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    #1;
    chk(10'(inv_cnt - a), 10'd2, "invalid syms");
    chk({9'h0, (pair_cnt - b) inside {[3*TK-4 : 3*TK]}}, 10'h001, "length");
    chk({7'h0, cse_q, wp_q, exp_q}, 10'h007, "expiry");
    chk(10'(scrub_phase_q), 10'(SCRUB_OFF), "scrub end");
    $display("test scrub done");
    wrap_up();
  end
endmodule
